// File: logic/sgm_pkg.sv
// constants, field layouts and carriers for the measurement timer mode block
`default_nettype none
package sgm_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned 32-bit word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_COUNT  = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0C;
  localparam logic [7:0] OFS_CAPT   = 8'h10;

  // ==========================================================================
  // widths, reset values and timing
  localparam int          CNT_W      = 24;
  localparam int          NARROW_W   = 16;
  localparam logic [23:0] RST_PERIOD = 24'hFFFFFF;
  localparam logic [11:0] RST_CTRL   = 12'h000;
  localparam int          RUN_LAG    = 2;     // run request pipeline stages; run status lags the request by RUN_LAG+1 cycles
  localparam int          NUM_PINS   = 3;
  localparam int          PIN_SIG    = 0;
  localparam int          PIN_WIN    = 1;
  localparam int          PIN_CLK    = 2;

  // status bit positions
  localparam int SB_RUN    = 0;
  localparam int SB_PMATCH = 1;
  localparam int SB_ACQ    = 2;

  // ==========================================================================
  // mode codes and timer clock sources
  localparam logic [3:0] MODE_TIMER     = 4'h0;
  localparam logic [3:0] MODE_GATED     = 4'h1;
  localparam logic [3:0] MODE_PERDUTY   = 4'h2;
  localparam logic [3:0] MODE_HILO      = 4'h3;
  localparam logic [3:0] MODE_WINDOWED  = 4'h4;
  localparam logic [3:0] MODE_GWINDOWED = 4'h5;
  localparam logic [3:0] MODE_FLIGHT    = 4'h6;
  localparam logic [3:0] MODE_CAPTURE   = 4'h7;
  localparam logic [3:0] MODE_COUNTER   = 4'h8;
  localparam logic [3:0] MODE_GCOUNTER  = 4'h9;
  localparam logic [3:0] MODE_WCOUNTER  = 4'hA;

  localparam logic [1:0] CSEL_SYS   = 2'h0;   // every system clock
  localparam logic [1:0] CSEL_PIN   = 2'h1;   // timer clock pin edges
  localparam logic [1:0] CSEL_PRESC = 2'h2;   // prescaled system clock

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // control register layout, bit 11 downward
  typedef struct packed {
    logic [3:0] mode;        // 11:8
    logic [1:0] clk_sel;     // 7:6
    logic       width24;     // 5
    logic       timer_clock_polarity; // 4
    logic       signal_polarity;      // 3
    logic       window_polarity;      // 2
    logic       repeat_en;   // 1
    logic       run_request_bit;      // 0
  } sgm_ctrl_s;

  // per-cycle events of the counting core
  typedef struct packed {
    logic inc;
    logic acq;
    logic restart;
  } sgm_evt_s;

endpackage
`default_nettype wire

// File: logic/sgm_timer.sv
// measurement timer: mode decode, plain timer and AXI4-Lite registers
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - polarity bits invert window, signal, timer clock
// - single mode: stop counting, clear run request
// - repeat mode: keep counting, newer results overwrite
// - timer mode: plain 16/24-bit up-counter, no capture
// - timer mode counts each tick while run set
// - timer mode: pin events never touch run request
// - timer mode paced by selected timer clock
// - count equals period: zero count, flag match
// - codes 0000-0111 decode to synchronous modes
// - 1000-1010 counter modes, 1011-1111 reserved
// - run status lags request except counter modes
module sgm_timer #(
  parameter int unsigned PRESC_DIV = 4      // prescaled clock divide ratio
) (
  input  wire logic        sys_clk,         // 25 MHz system clock
  input  wire logic        arst_n,          // async reset, active low
  input  wire logic        measured_signal_input, // measured signal pin
  input  wire logic        window_input,    // window pin
  input  wire logic        timer_clock_pin, // external timer clock pin
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write byte enables
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  output logic             run_status_bit,  // timer actually running
  output logic             period_match_pulse, // one cycle per match
  output logic             acq_done_pulse   // one cycle per acquisition
);

  // ==========================================================================
  // state
  typedef struct packed {
    sgm_pkg::sgm_ctrl_s                 ctrl;
    logic [sgm_pkg::CNT_W-1:0]          count_register;
    logic [sgm_pkg::CNT_W-1:0]          period_register;
    logic [sgm_pkg::CNT_W-1:0]          capture;
    logic                               pmatch_flag;
    logic                               acq_flag;
    logic [sgm_pkg::NUM_PINS-1:0]       sync1;
    logic [sgm_pkg::NUM_PINS-1:0]       sync2;
    logic [sgm_pkg::NUM_PINS-1:0]       sync3;
    logic [sgm_pkg::NUM_PINS-1:0]       level;
    logic [sgm_pkg::NUM_PINS-1:0]       prev;
    logic [15:0]                        presc;
    logic [sgm_pkg::RUN_LAG-1:0]        run_pipe;
    logic                               run_status;
    logic                               pm_pulse;
    logic                               acq_pulse;
    logic                               awready;
    logic                               aw_have;
    logic [7:0]                         aw_addr;
    logic                               wready;
    logic                               w_have;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               arready;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
  } sgm_state_s;

  sgm_state_s                   state_reg;
  sgm_state_s                   state_next;
  logic [sgm_pkg::NUM_PINS-1:0] pins;
  logic [sgm_pkg::NUM_PINS-1:0] pol;
  logic [sgm_pkg::NUM_PINS-1:0] lvl;

  assign pins = {timer_clock_pin, window_input, measured_signal_input};
  assign pol  = {state_reg.ctrl.timer_clock_polarity,
                 state_reg.ctrl.window_polarity,
                 state_reg.ctrl.signal_polarity};

  // ==========================================================================
  // polarity applied to the filtered pin levels
  genvar gi;
  generate
    for (gi = 0; gi < sgm_pkg::NUM_PINS; gi++) begin : g_pol
      assign lvl[gi] = state_reg.level[gi] ^ pol[gi];
    end
  endgenerate

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    sgm_state_s                q;
    sgm_state_s                n;
    sgm_pkg::sgm_evt_s         ev;
    logic                      sig_rise;
    logic                      sig_fall;
    logic                      win_rise;
    logic                      win_fall;
    logic                      tick;
    logic                      presc_hit;
    logic                      counter_mode;
    logic                      reserved;
    logic                      enable;
    logic                      match;
    logic [sgm_pkg::CNT_W-1:0] mask;
    logic [31:0]               word;
    logic [7:0]                wa;
    logic [7:0]                ra;
    q            = state_reg;
    n            = state_reg;
    ev           = '0;
    word         = 32'h00000000;
    n.pm_pulse   = 1'b0;
    n.acq_pulse  = 1'b0;

    // three-stage input filter: a level is taken once stages 2 and 3 agree
    n.sync1 = pins;
    n.sync2 = q.sync1;
    n.sync3 = q.sync2;
    for (int i = 0; i < sgm_pkg::NUM_PINS; i++) begin
      if (q.sync2[i] == q.sync3[i]) begin
        n.level[i] = q.sync3[i];
      end
    end
    n.prev   = lvl;
    sig_rise = lvl[sgm_pkg::PIN_SIG] & ~q.prev[sgm_pkg::PIN_SIG];
    sig_fall = ~lvl[sgm_pkg::PIN_SIG] & q.prev[sgm_pkg::PIN_SIG];
    win_rise = lvl[sgm_pkg::PIN_WIN] & ~q.prev[sgm_pkg::PIN_WIN];
    win_fall = ~lvl[sgm_pkg::PIN_WIN] & q.prev[sgm_pkg::PIN_WIN];

    // prescaler gives a one-cycle enable every PRESC_DIV cycles
    presc_hit = (q.presc == 16'(PRESC_DIV - 1));
    n.presc   = presc_hit ? 16'h0000 : q.presc + 16'h0001;

    // timer clock source; every step except in the counter modes is paced by this tick
    unique case (q.ctrl.clk_sel)
      sgm_pkg::CSEL_SYS:   tick = 1'b1;
      sgm_pkg::CSEL_PIN:   tick = lvl[sgm_pkg::PIN_CLK] &
                                  ~q.prev[sgm_pkg::PIN_CLK];
      sgm_pkg::CSEL_PRESC: tick = presc_hit;
      default:             tick = 1'b0;
    endcase

    // counter modes see the request directly, the rest through the lag
    counter_mode = q.ctrl.mode inside {sgm_pkg::MODE_COUNTER,
                   sgm_pkg::MODE_GCOUNTER, sgm_pkg::MODE_WCOUNTER};
    n.run_pipe   = {q.run_pipe[sgm_pkg::RUN_LAG-2:0], q.ctrl.run_request_bit};
    n.run_status = counter_mode ? q.ctrl.run_request_bit
                                : q.run_pipe[sgm_pkg::RUN_LAG-1];
    // gating on the request too stops a single run at once, not after lag
    enable = q.run_status & q.ctrl.run_request_bit;

    // mode decode; measurement modes except capture restart the count on each result
    reserved = 1'b0;
    unique case (q.ctrl.mode)
      sgm_pkg::MODE_TIMER: begin
        ev.inc = tick;
      end
      sgm_pkg::MODE_GATED: begin
        ev.inc = tick & lvl[sgm_pkg::PIN_WIN];
      end
      sgm_pkg::MODE_PERDUTY, sgm_pkg::MODE_FLIGHT: begin
        ev.inc     = tick;
        ev.acq     = sig_rise;
        ev.restart = sig_rise;
      end
      sgm_pkg::MODE_HILO: begin
        ev.inc     = tick;
        ev.acq     = sig_rise | sig_fall;
        ev.restart = sig_rise | sig_fall;
      end
      sgm_pkg::MODE_WINDOWED: begin
        ev.inc     = tick;
        ev.acq     = win_rise;
        ev.restart = win_rise;
      end
      sgm_pkg::MODE_GWINDOWED: begin
        ev.inc     = tick & lvl[sgm_pkg::PIN_SIG];
        ev.acq     = win_rise;
        ev.restart = win_rise;
      end
      sgm_pkg::MODE_CAPTURE: begin
        ev.inc = tick;
        ev.acq = sig_rise;
      end
      sgm_pkg::MODE_COUNTER: begin
        ev.inc = sig_rise;
      end
      sgm_pkg::MODE_GCOUNTER: begin
        ev.inc = sig_rise & lvl[sgm_pkg::PIN_WIN];
      end
      sgm_pkg::MODE_WCOUNTER: begin
        ev.inc     = sig_rise & lvl[sgm_pkg::PIN_WIN];
        ev.acq     = win_fall;
        ev.restart = win_fall;
      end
      default: begin
        reserved = 1'b1;
      end
    endcase
    if (!enable || reserved) begin
      ev = '0;
    end

    // count width: upper byte cleared by each count step in 16-bit operation
    mask  = q.ctrl.width24 ? {sgm_pkg::CNT_W{1'b1}}
                           : sgm_pkg::CNT_W'({sgm_pkg::NARROW_W{1'b1}});
    match = ((q.count_register & mask) == (q.period_register & mask));

    // a result alone leaves the count running; only restart or a period match zeroes it
    if (ev.acq) begin
      n.capture = q.count_register & mask;
    end
    if (ev.restart) begin
      n.count_register = '0;
    end else if (ev.inc && match) begin
      n.count_register = '0;
      n.pm_pulse       = 1'b1;
    end else if (ev.inc) begin
      n.count_register = (q.count_register + 1'b1) & mask;
    end
    n.acq_pulse = ev.acq | (ev.inc & match &
                  (q.ctrl.mode == sgm_pkg::MODE_TIMER));
    // single acquisition ends the run; pins alone never set the request
    if (n.acq_pulse && !q.ctrl.repeat_en) begin
      n.ctrl.run_request_bit = 1'b0;
    end

    // ========================================================================
    // AXI4-Lite write: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // hardware flags set first; a clear in the same cycle loses to a set
    n.pmatch_flag = q.pmatch_flag | n.pm_pulse;
    n.acq_flag    = q.acq_flag | n.acq_pulse;
    wa = {q.aw_addr[7:2], 2'b00};
    if (q.aw_have && q.w_have && !q.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = sgm_pkg::RESP_OKAY;
      unique case (wa)
        sgm_pkg::OFS_CTRL: begin
          word   = merge({20'h00000, q.ctrl}, q.w_data, q.w_strb);
          n.ctrl = sgm_pkg::sgm_ctrl_s'(word[11:0]);
        end
        sgm_pkg::OFS_STAT: begin
          if (q.w_strb[0] && q.w_data[sgm_pkg::SB_PMATCH] && !n.pm_pulse) begin
            n.pmatch_flag = 1'b0;
          end
          if (q.w_strb[0] && q.w_data[sgm_pkg::SB_ACQ] && !n.acq_pulse) begin
            n.acq_flag = 1'b0;
          end
        end
        sgm_pkg::OFS_COUNT: begin
          word = merge({8'h00, q.count_register}, q.w_data, q.w_strb);
          n.count_register = word[sgm_pkg::CNT_W-1:0];
        end
        sgm_pkg::OFS_PERIOD: begin
          word = merge({8'h00, q.period_register}, q.w_data, q.w_strb);
          n.period_register = word[sgm_pkg::CNT_W-1:0];
        end
        sgm_pkg::OFS_CAPT: begin
          n.bresp = sgm_pkg::RESP_OKAY;             // read-only, write dropped
        end
        default: begin
          n.bresp = sgm_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.awready = ~n.aw_have;
    n.wready  = ~n.w_have;

    // ========================================================================
    // AXI4-Lite read: one outstanding, answer one cycle after acceptance
    ra = {s_axi_araddr[7:2], 2'b00};
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = sgm_pkg::RESP_OKAY;
      unique case (ra)
        sgm_pkg::OFS_CTRL:   n.rdata = {20'h00000, q.ctrl};
        sgm_pkg::OFS_STAT:   n.rdata = {29'h00000000, q.acq_flag,
                                        q.pmatch_flag, q.run_status};
        sgm_pkg::OFS_COUNT:  n.rdata = {8'h00, q.count_register};
        sgm_pkg::OFS_PERIOD: n.rdata = {8'h00, q.period_register};
        sgm_pkg::OFS_CAPT:   n.rdata = {8'h00, q.capture};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = sgm_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.arready  = ~n.rvalid;
    state_next = n;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg                 <= '0;
      state_reg.ctrl            <= sgm_pkg::RST_CTRL;
      state_reg.period_register <= sgm_pkg::RST_PERIOD;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready      = state_reg.awready;
  assign s_axi_wready       = state_reg.wready;
  assign s_axi_bvalid       = state_reg.bvalid;
  assign s_axi_bresp        = state_reg.bresp;
  assign s_axi_arready      = state_reg.arready;
  assign s_axi_rvalid       = state_reg.rvalid;
  assign s_axi_rdata        = state_reg.rdata;
  assign s_axi_rresp        = state_reg.rresp;
  assign run_status_bit     = state_reg.run_status;
  assign period_match_pulse = state_reg.pm_pulse;
  assign acq_done_pulse     = state_reg.acq_pulse;

endmodule
`default_nettype wire

// File: tb/sgm_timer_assertions.sv
// bus handshake checker for the measurement timer block
`timescale 1ns/100ps
`default_nettype none
module sgm_timer_assertions (
  input wire logic        sys_clk,       // clock
  input wire logic        arst_n,        // async reset, active low
  input wire logic        s_axi_awvalid, // write address valid
  input wire logic        s_axi_awready, // write address ready
  input wire logic        s_axi_wvalid,  // write data valid
  input wire logic        s_axi_wready,  // write data ready
  input wire logic [1:0]  s_axi_bresp,   // write response
  input wire logic        s_axi_bvalid,  // write response valid
  input wire logic        s_axi_bready,  // write response ready
  input wire logic        s_axi_arvalid, // read address valid
  input wire logic        s_axi_arready, // read address ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic [1:0]  s_axi_rresp,   // read response
  input wire logic        s_axi_rvalid,  // read data valid
  input wire logic        s_axi_rready   // read data ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ==========================================================================
  // write answer two edges after both are taken, read answer one edge
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  // a taken write closes both write channels next cycle; a pending read answer closes read address
  write_refuse_a: assert property (wr_taken
    |=> !s_axi_awready && !s_axi_wready)
    else $error("write channel still open");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while answer pending");
  // answers stand until taken, then drop
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("bvalid not released");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed");
  rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("rvalid not released");
  resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0
    || s_axi_bresp == 2'h2) else $error("bad write response code");
endmodule
`default_nettype wire

// File: tb/sgm_timer_tb.sv
// self-checking bench for the measurement timer block
`timescale 1ns/100ps
`default_nettype none
module sgm_timer_tb;
  // ==========================================================================
  // signals and bookkeeping
  logic        sys_clk = 0, arst_n = 0, sig_in = 0, win_in = 0, tclk = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, seed = 32'hF16D;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, run_st, pm, acq;
  logic [1:0]  bresp, rresp;
  logic        noise = 0;
  int          errors = 0, checks_done = 0, cyc = 0, pm_cnt = 0;
  int          t_last = 0, t_prev = 0, p, pm0, n;
  int          acq_cnt = 0, a0;
  localparam int DIV = 4;

  always #20 sys_clk = ~sys_clk;

  sgm_timer #(.PRESC_DIV(DIV)) sgm_timer_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .measured_signal_input(sig_in),
    .window_input(win_in), .timer_clock_pin(tclk), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .run_status_bit(run_st),
    .period_match_pulse(pm), .acq_done_pulse(acq));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // control word: mode, pacing source, polarity {clk,sig,win}, repeat, run
  function automatic logic [31:0] cfg(input logic [3:0] m,
    input logic [1:0] cs, input logic [2:0] pol, input logic rep,
    input logic run);
    return {20'h0, m, cs, 1'b1, pol, rep, run};
  endfunction

  // ==========================================================================
  // period match log; pin noise only during timer runs, pins must not matter
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (acq === 1'b1) acq_cnt <= acq_cnt + 1;
    if (pm === 1'b1) begin
      pm_cnt <= pm_cnt + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (noise) begin
      seed = xs(seed);
      sig_in <= seed[3];
      win_in <= seed[9];
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, e);
    checks_done++;
    if (seen !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // bus master: hold each channel until its ready, wait for the answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = 2'h0);
    bit got;
    got = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!got) begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) got = 1;
    end
    bready <= 0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er = 2'h0);
    bit got;
    got = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!got) begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) got = 1;
    end
    rready <= 0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    chk("rdata", rdata, e);
  endtask

  // edges from the run write's answer until run status is seen
  task automatic lag(input int e);
    int k;
    k = 0;
    while (run_st !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      k++;
    end
    chk("run lag", 32'(k), 32'(e));
  endtask

  task automatic setp(input int w, input logic v);
    if (w == 0) sig_in <= v;
    else tclk <= v;
    repeat (6) @(posedge sys_clk);
  endtask

  // k pulses then a last rise: k+1 rises, k falls; the run starts only after
  // the polarity has settled, since flipping it can fake one edge
  task automatic pin_run(input logic [3:0] m, input logic [1:0] cs,
    input logic [2:0] pol, input int w, input int kind);
    int k;
    seed = xs(seed);
    k = 1 + seed[1:0];
    pm0 = pm_cnt;
    a0 = acq_cnt;
    axi_wr(sgm_pkg::OFS_COUNT, 0);
    axi_wr(sgm_pkg::OFS_CTRL, cfg(m, cs, pol, 1, 0));
    repeat (10) @(posedge sys_clk);
    axi_wr(sgm_pkg::OFS_CTRL, cfg(m, cs, pol, 1, 1));
    if (m <= 4'hA) lag(m[3] ? 1 : sgm_pkg::RUN_LAG + 1);
    repeat (8) @(posedge sys_clk);
    repeat (k) begin
      setp(w, 1);
      setp(w, 0);
    end
    setp(w, 1);
    repeat (8) @(posedge sys_clk);
    rdc(sgm_pkg::OFS_COUNT,
        kind == 0 ? 0 : kind == 1 ? k : k + 1);
    chk("match count", 32'(pm_cnt - pm0), 0);
    chk("acq count", 32'(acq_cnt - a0), 0);
    axi_wr(sgm_pkg::OFS_CTRL, cfg(m, cs, pol, 1, 0));
    setp(w, 0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1;
    rdc(sgm_pkg::OFS_CTRL, 0);
    rdc(sgm_pkg::OFS_PERIOD, 32'h00FFFFFF);
    rdc(sgm_pkg::OFS_COUNT, 0);
    rdc(sgm_pkg::OFS_STAT, 0);
    rdc(8'h20, 0, sgm_pkg::RESP_SLVERR);
    axi_wr(8'h20, 32'h5, sgm_pkg::RESP_SLVERR);
    // single timer run with random period, pins wiggling meanwhile
    seed = xs(seed);
    p = 5 + seed[3:0];
    axi_wr(sgm_pkg::OFS_PERIOD, p);
    pm0 = pm_cnt;
    a0 = acq_cnt;
    noise <= 1;
    axi_wr(sgm_pkg::OFS_CTRL, cfg(0, 0, 0, 0, 1));
    lag(sgm_pkg::RUN_LAG + 1);
    repeat (3 * (p + 1) + 10) @(posedge sys_clk);
    noise <= 0;
    chk("single matches", 32'(pm_cnt - pm0), 1);
    chk("single acqs", 32'(acq_cnt - a0), 1);
    rdc(sgm_pkg::OFS_CTRL, cfg(0, 0, 0, 0, 0));
    // pins back to idle so later edge counts start from a known level
    sig_in <= 0;
    win_in <= 0;
    rdc(sgm_pkg::OFS_COUNT, 0);
    rdc(sgm_pkg::OFS_STAT, 32'h6);
    axi_wr(sgm_pkg::OFS_STAT, 32'h6);
    rdc(sgm_pkg::OFS_STAT, 0);
    // repeated runs paced by system clock, then by the prescaler
    for (int cs = 0; cs < 3; cs += 2) begin
      pm0 = pm_cnt;
      axi_wr(sgm_pkg::OFS_CTRL, cfg(0, cs, 0, 1, 1));
      n = 0;
      while (pm_cnt < pm0 + 3 && n < 4000) begin
        @(posedge sys_clk);
        n++;
      end
      chk("match spacing", 32'(t_last - t_prev),
          (p + 1) * (cs ? DIV : 1));
      rdc(sgm_pkg::OFS_CTRL, cfg(0, cs, 0, 1, 1));
      axi_wr(sgm_pkg::OFS_CTRL, cfg(0, cs, 0, 1, 0));
    end
    axi_wr(sgm_pkg::OFS_PERIOD, 32'h00FFFFFF);
    pin_run(4'h0, 2'h1, 3'b000, 2, 2);
    pin_run(4'h0, 2'h1, 3'b100, 2, 1);
    pin_run(4'h8, 2'h0, 3'b000, 0, 2);
    pin_run(4'h8, 2'h0, 3'b010, 0, 1);
    pin_run(4'h9, 2'h0, 3'b001, 0, 2);
    pin_run(4'h9, 2'h0, 3'b000, 0, 0);
    pin_run(4'h1, 2'h1, 3'b001, 2, 2);
    pin_run(4'hA, 2'h0, 3'b001, 0, 2);
    pin_run(4'h0, 2'h3, 3'b000, 2, 0);
    axi_wr(sgm_pkg::OFS_PERIOD, p);
    for (int m = 11; m < 16; m++)
      pin_run(m[3:0], 2'h0, 3'b000, 0, 0);
    end_of_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    #(40 * 40000);
    errors++;
    end_of_test();
  end
endmodule

bind sgm_timer sgm_timer_assertions sgm_timer_assertions_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
